// File: mfl_led_coder.v
// Motor fault LED coder: shows controller state and faults on one LED.
// Assumes fault flags are synchronous levels from the sensing circuitry.
//
// Notes on behaviour
// - The LED is dark while idle and steadily lit while the motor runs normally.
// - A stall event shows two-blink groups twice, then the LED returns to normal.
// - Over-current shows three-blink groups and overheat four-blink groups while present and for ten seconds after, then clears.
// - Over-voltage shows five-blink groups while present and clears ten seconds after it ends.
// - Under-voltage shows six-blink groups while present and clears ten seconds after it ends.
// - During the over- or under-voltage recovery time the motor is still allowed to run.
// - A shorted wiring fault shows seven-blink groups until the fault is corrected.
`timescale 1ns/1ps
`include "mfl_consts.vh"

module mfl_led_coder #(
    parameter [31:0] HOLD_CYC  = `MFL_HOLD_CYC,
    parameter [31:0] ON_CYC    = `MFL_ON_CYC,
    parameter [31:0] OFF_CYC   = `MFL_OFF_CYC,
    parameter [31:0] PAUSE_CYC = `MFL_PAUSE_CYC
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        reset_i,
    // Controller state
    input  wire        motor_running_i,
    // Fault flags
    input  wire        stall_i,
    input  wire        overcurrent_i,
    input  wire        overheat_i,
    input  wire        overvolt_i,
    input  wire        undervolt_i,
    input  wire        wire_short_i,
    // Outputs
    output reg         led_o,
    output wire        run_permit_o,
    output reg  [2:0]  code_o
);

    // ------------------------------------------------------------
    // Hold timers and latched indications
    // ------------------------------------------------------------
    reg        stall_act;
    reg [1:0]  stall_groups;
    reg        oc_act;
    reg        oh_act;
    reg        ov_act;
    reg        uv_act;
    reg [31:0] oc_tmr;
    reg [31:0] oh_tmr;
    reg [31:0] ov_tmr;
    reg [31:0] uv_tmr;
    reg        stall_d;
    wire       stall_last;
    wire       group_done;
    wire       blink_led;
    reg [2:0]  next_code;

    // Countdown: reload while cause present, clear flag at zero
    function [31:0] hold_next;
        input        cause;
        input [31:0] tmr;
        begin
            if (cause)
                hold_next = HOLD_CYC - 32'h1;
            else if (tmr != 32'h0)
                hold_next = tmr - 32'h1;
            else
                hold_next = 32'h0;
        end
    endfunction

    always @(posedge clk_i) begin
        if (reset_i) begin
            stall_act    <= 1'b0;
            stall_groups <= 2'h0;
            stall_d      <= 1'b0;
            oc_act       <= 1'b0;
            oh_act       <= 1'b0;
            ov_act       <= 1'b0;
            uv_act       <= 1'b0;
            oc_tmr       <= 32'h0;
            oh_tmr       <= 32'h0;
            ov_tmr       <= 32'h0;
            uv_tmr       <= 32'h0;
        end else begin
            stall_d <= stall_i;
            // Stall counts groups only while it is the shown code
            if (stall_i && !stall_d) begin
                stall_act    <= 1'b1;
                stall_groups <= 2'h0;
            end else if (stall_act && group_done && code_o == `MFL_N_STALL) begin
                if (stall_groups + 2'h1 >= `MFL_STALL_GROUPS)
                    stall_act <= 1'b0;
                stall_groups <= stall_groups + 2'h1;
            end
            // Event faults hold for a fixed time from the last sighting
            oc_tmr <= hold_next(overcurrent_i, oc_tmr);
            oh_tmr <= hold_next(overheat_i, oh_tmr);
            oc_act <= overcurrent_i || (oc_tmr > 32'h1);
            oh_act <= overheat_i || (oh_tmr > 32'h1);
            // Supply faults: show while present, clear after recovery time
            ov_tmr <= hold_next(overvolt_i, ov_tmr);
            uv_tmr <= hold_next(undervolt_i, uv_tmr);
            ov_act <= overvolt_i || (ov_tmr > 32'h1);
            uv_act <= undervolt_i || (uv_tmr > 32'h1);
        end
    end

    // Only a live supply fault inhibits the motor; recovery does not
    assign run_permit_o = !overvolt_i && !undervolt_i;

    // Final stall group just ended; the blinker has already relaunched
    assign stall_last = stall_act && group_done && (code_o == `MFL_N_STALL)
                        && (stall_groups + 2'h1 >= `MFL_STALL_GROUPS);

    // ------------------------------------------------------------
    // Priority select: most severe condition wins
    // ------------------------------------------------------------
    always @* begin
        if (wire_short_i)
            next_code = `MFL_N_SHORT;
        else if (uv_act)
            next_code = `MFL_N_UNDERVOLT;
        else if (ov_act)
            next_code = `MFL_N_OVERVOLT;
        else if (oh_act)
            next_code = `MFL_N_OVERHEAT;
        else if (oc_act)
            next_code = `MFL_N_OVERCUR;
        else if (stall_act)
            next_code = `MFL_N_STALL;
        else
            next_code = 3'h0;
    end

    always @(posedge clk_i) begin
        if (reset_i)
            code_o <= 3'h0;
        else
            code_o <= next_code;
    end

    // Restart the pattern whenever the shown code changes
    wire blink_run = (code_o != 3'h0) && (code_o == next_code);

    mfl_blinker #(
        .ON_CYC    (ON_CYC),
        .OFF_CYC   (OFF_CYC),
        .PAUSE_CYC (PAUSE_CYC)
    ) u_blinker (
        .clk_i        (clk_i),
        .reset_i      (reset_i),
        .run_i        (blink_run),
        .count_i      (code_o),
        .led_o        (blink_led),
        .group_done_o (group_done)
    );

    // ------------------------------------------------------------
    // LED drive
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (reset_i)
            led_o <= 1'b0;
        // Dark while a code is being dropped, so no stray flash trails a pattern
        else if (code_o != 3'h0)
            led_o <= blink_led && (code_o == next_code) && !stall_last;
        else
            led_o <= motor_running_i;
    end

endmodule

// File: mfl_consts.vh
// Constants for the motor fault LED coder: blink timing and recovery time.
// Assumes a 40 MHz system clock.
`ifndef MFL_CONSTS_VH
`define MFL_CONSTS_VH

`define MFL_CLK_HZ            40000000
// Blink timing in milliseconds
`define MFL_ON_MS             250
`define MFL_OFF_MS            250
`define MFL_PAUSE_MS          1500
// Fault hold and recovery time in seconds
`define MFL_HOLD_S            10
// Derived cycle counts
`define MFL_ON_CYC            ((`MFL_CLK_HZ / 1000) * `MFL_ON_MS)
`define MFL_OFF_CYC           ((`MFL_CLK_HZ / 1000) * `MFL_OFF_MS)
`define MFL_PAUSE_CYC         ((`MFL_CLK_HZ / 1000) * `MFL_PAUSE_MS)
`define MFL_HOLD_CYC          (`MFL_CLK_HZ * `MFL_HOLD_S)
// Blink counts per condition
`define MFL_N_STALL           3'h2
`define MFL_N_OVERCUR         3'h3
`define MFL_N_OVERHEAT        3'h4
`define MFL_N_OVERVOLT        3'h5
`define MFL_N_UNDERVOLT       3'h6
`define MFL_N_SHORT           3'h7
// Stall pattern is shown this many groups
`define MFL_STALL_GROUPS      2'h2

`endif

// File: mfl_blinker.v
// Blink group generator: emits groups of N pulses separated by a pause.
// Assumes the caller holds count_i stable while run_i is high.
`timescale 1ns/1ps
`include "mfl_consts.vh"

module mfl_blinker #(
    parameter [31:0] ON_CYC    = `MFL_ON_CYC,
    parameter [31:0] OFF_CYC   = `MFL_OFF_CYC,
    parameter [31:0] PAUSE_CYC = `MFL_PAUSE_CYC
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        reset_i,
    // Control
    input  wire        run_i,
    input  wire [2:0]  count_i,
    // Pattern output
    output reg         led_o,
    output reg         group_done_o
);

    // ------------------------------------------------------------
    // Phase sequencer
    // ------------------------------------------------------------
    localparam [2:0] ST_ON    = 3'h1;
    localparam [2:0] ST_OFF   = 3'h2;
    localparam [2:0] ST_PAUSE = 3'h4;

    reg [2:0]  state;
    reg [31:0] timer;
    reg [2:0]  blinks;

    always @(posedge clk_i) begin
        group_done_o <= 1'b0;
        if (reset_i || !run_i) begin
            state  <= ST_ON;
            timer  <= 32'h0;
            blinks <= 3'h0;
            led_o  <= 1'b0;
        end else begin
            timer <= timer + 32'h1;
            case (state)
                ST_ON: begin
                    led_o <= 1'b1;
                    if (timer >= ON_CYC - 32'h1) begin
                        state  <= ST_OFF;
                        timer  <= 32'h0;
                        led_o  <= 1'b0;
                        blinks <= blinks + 3'h1;
                    end
                end
                ST_OFF: begin
                    led_o <= 1'b0;
                    if (timer >= OFF_CYC - 32'h1) begin
                        timer <= 32'h0;
                        if (blinks >= count_i) begin
                            state <= ST_PAUSE;
                        end else begin
                            state <= ST_ON;
                            led_o <= 1'b1;
                        end
                    end
                end
                ST_PAUSE: begin
                    led_o <= 1'b0;
                    if (timer >= PAUSE_CYC - 32'h1) begin
                        timer        <= 32'h0;
                        blinks       <= 3'h0;
                        state        <= ST_ON;
                        led_o        <= 1'b1;
                        group_done_o <= 1'b1;
                    end
                end
                default: begin
                    state <= ST_ON;
                    timer <= 32'h0;
                end
            endcase
        end
    end

endmodule

// File: mfl_led_coder_asserts.sv
// Port checker for the motor fault LED coder.
// Assumes it is bound to the coder and sees only its ports.
`timescale 1ns/1ps
module mfl_led_coder_chk (
    input wire       clk_i,
    input wire       reset_i,
    input wire       motor_running_i,
    input wire       overcurrent_i,
    input wire       overheat_i,
    input wire       overvolt_i,
    input wire       undervolt_i,
    input wire       wire_short_i,
    input wire       led_o,
    input wire       run_permit_o,
    input wire [2:0] code_o
);
    // Inputs one cycle back: a fault seen then may already outrank the one watched
    reg undervolt_q = 1'b0;
    reg overvolt_q  = 1'b0;
    reg overheat_q  = 1'b0;
    always @(posedge clk_i) begin
        undervolt_q <= undervolt_i;
        overvolt_q  <= overvolt_i;
        overheat_q  <= overheat_i;
    end
    // Nothing of higher rank is shown or on its way in
    wire quiet = code_o == 3'h0 && !wire_short_i && !undervolt_i && !undervolt_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    reset_clear_a: assert property ($fell(reset_i) |-> code_o == 3'h0 && !led_o)
        else $error("outputs set after reset");
    idle_led_a: assert property ($past(code_o) == 3'h0 && code_o == 3'h0 |-> led_o == $past(motor_running_i))
        else $error("LED not following run state");
    permit_a: assert property (run_permit_o == !(overvolt_i || undervolt_i))
        else $error("run permit wrong");
    short_code_a: assert property (wire_short_i |=> code_o == 3'h7)
        else $error("short not shown");
    uv_code_a: assert property ((undervolt_i && !wire_short_i) [*2] |=> code_o == 3'h6)
        else $error("under-voltage not shown");
    ov_code_a: assert property (quiet && overvolt_i ##1 !wire_short_i |=> code_o == 3'h5)
        else $error("over-voltage not shown");
    oh_code_a: assert property (quiet && !overvolt_i && !overvolt_q && overheat_i ##1 !wire_short_i
                                |=> code_o == 3'h4)
        else $error("overheat not shown");
    oc_code_a: assert property (quiet && !overvolt_i && !overvolt_q && !overheat_i && !overheat_q && overcurrent_i
                                ##1 !wire_short_i
                                |=> code_o == 3'h3)
        else $error("over-current not shown");
    stall_seen_c: cover property (code_o == 3'h2);
    short_seen_c: cover property (code_o == 3'h7);
    recover_c: cover property ($rose(run_permit_o));
endmodule
bind mfl_led_coder mfl_led_coder_chk mfl_led_coder_chk_i (.clk_i(clk_i), .reset_i(reset_i),
    .motor_running_i(motor_running_i), .overcurrent_i(overcurrent_i), .overheat_i(overheat_i),
    .overvolt_i(overvolt_i), .undervolt_i(undervolt_i), .wire_short_i(wire_short_i), .led_o(led_o),
    .run_permit_o(run_permit_o), .code_o(code_o));

// File: mfl_led_view.sv
// LED viewer model: counts the blinks of the last group seen.
// Assumes a dark spell longer than GAP_CYC parts two groups.
`timescale 1ns/1ps
module mfl_led_view #(
    parameter [31:0] GAP_CYC = 32'h7
) (
    input  wire       clk_i,
    input  wire       led_i,
    output reg  [2:0] grp_blinks_o = 3'h0
);
    reg [31:0] dark   = 32'h0;
    reg [2:0]  blinks = 3'h0;
    reg        led_q  = 1'b0;
    always @(posedge clk_i) begin
        led_q <= led_i;
        dark  <= led_i ? 32'h0 : dark + 32'h1;
        if (led_i && !led_q)
            blinks <= blinks + 3'h1;
        else if (dark == GAP_CYC && blinks != 3'h0) begin
            grp_blinks_o <= blinks;
            blinks       <= 3'h0;
        end
    end
endmodule

// File: mfl_led_coder_bench.sv
// Bench for the motor fault LED coder with an LED viewer on its output.
// Assumes shortened hold and blink counts; inputs move on falling edges.
`timescale 1ns/1ps
module mfl_led_coder_bench;
    reg        clk_i, reset_i;
    reg  [6:0] inp;
    reg  [7:0] n;
    wire       led, permit;
    wire [2:0] code, gb;
    integer    n_fail, samples_checked;
    mfl_led_coder #(.HOLD_CYC(32'hC8), .ON_CYC(32'h4), .OFF_CYC(32'h4), .PAUSE_CYC(32'hA)) mfl_led_coder_i (
        .clk_i(clk_i), .reset_i(reset_i), .motor_running_i(inp[6]), .stall_i(inp[5]), .overcurrent_i(inp[4]),
        .overheat_i(inp[3]), .overvolt_i(inp[2]), .undervolt_i(inp[1]), .wire_short_i(inp[0]), .led_o(led),
        .run_permit_o(permit), .code_o(code));
    mfl_led_view mfl_led_view_i (.clk_i(clk_i), .led_i(led), .grp_blinks_o(gb));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // Waits c falling edges, then compares code, LED, last group or permit
    task chk(input integer c, input [1:0] sel, input [7:0] exp);
        repeat (c) @(negedge clk_i);
        samples_checked = samples_checked + 1;
        if ((sel[1] ? (sel[0] ? {7'h0, permit} : {5'h0, gb}) : (sel[0] ? {7'h0, led} : {5'h0, code})) !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH at %0t: output %0d wrong", $time, sel);
        end
    endtask
    task complete_run;
        $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task t_stall;
        chk(0, 2'h1, 8'h0);
        inp = 7'h40;
        chk(3, 2'h1, 8'h1);
        inp = 7'h20;
        chk(3, 2'h0, 8'h2);
        chk(45, 2'h0, 8'h2);
        chk(22, 2'h0, 8'h0);
        chk(0, 2'h2, 8'h2);
        chk(0, 2'h1, 8'h0);
        inp = 7'h40;
        chk(2, 2'h1, 8'h1);
        inp = 7'h00;
        $display("test idle_stall ended");
    endtask
    // Over-current, overheat, over- and under-voltage in rising rank
    task t_faults;
        for (n = 8'h3; n < 8'h7; n = n + 8'h1) begin
            inp = 7'h01 << (8'h7 - n);
            chk(3, 2'h0, n);
            chk(0, 2'h3, {7'h0, n < 8'h5});
            chk(100, 2'h2, n);
            inp = 7'h00;
            chk(185, 2'h0, n);
            chk(0, 2'h3, 8'h1);
            chk(30, 2'h0, 8'h0);
        end
        $display("test faults ended");
    endtask
    task t_short;
        inp = 7'h05;
        chk(3, 2'h0, 8'h7);
        chk(250, 2'h0, 8'h7);
        chk(0, 2'h2, 8'h7);
        inp = 7'h04;
        chk(3, 2'h0, 8'h5);
        inp = 7'h06;
        chk(3, 2'h0, 8'h6);
        chk(0, 2'h3, 8'h0);
        inp = 7'h00;
        chk(230, 2'h0, 8'h0);
        $display("test short ended");
    endtask
    initial begin
        n_fail = 0;
        samples_checked = 0;
        {reset_i, inp, n} = {1'b1, 7'h00, 8'h0};
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        reset_i = 1'b0;
        t_stall;
        t_faults;
        t_short;
        complete_run;
    end
endmodule
